// ==== hw/tfcsb_bridge.sv ====
// bridge end: first-beat function capture and selected credit limit reporting
// Function
// - app drives physical function per TLP
// - VF TLPs carry parent physical function
// - sample physical function at start and valid
// - app flags virtual function TLPs
// - sample VF flag at start and valid
// - app drives VF offset within its set
// - VF offset below VF count, max 2048
// - sample VF offset at start and valid
// - VF offset ignored for PF TLPs
// - 12-bit data limit, 16-byte units
// - outputs follow select two cycles later
// - select 00 posted, 01 nonposted, 10 completion
// - 8-bit header limit, 20-byte units
// - start counts only with valid
`timescale 1ns/1ps
module tfcsb_bridge
  import tfcsb_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  tfcsb_if.bridge LINK,
  input wire logic [DCRED_W-1:0] POSTED_DATA_LIMIT,
  input wire logic [HCRED_W-1:0] POSTED_HDR_LIMIT,
  input wire logic [DCRED_W-1:0] NONPOSTED_DATA_LIMIT,
  input wire logic [HCRED_W-1:0] NONPOSTED_HDR_LIMIT,
  input wire logic [DCRED_W-1:0] CPL_DATA_LIMIT,
  input wire logic [HCRED_W-1:0] CPL_HDR_LIMIT,
  output logic [PF_W-1:0] TLP_PF_ID,
  output logic TLP_VF_ACTIVE,
  output logic [VF_W-1:0] TLP_VF_OFFSET,
  output logic TLP_ID_STROBE
);
  logic first_beat;
  logic [PF_W-1:0] pf_r;
  logic vf_act_r;
  logic [VF_W-1:0] vf_r;
  logic strobe_r;
  logic [SEL_W-1:0] sel_r;
  logic [DCRED_W-1:0] dcred_r;
  logic [HCRED_W-1:0] hcred_r;
  logic [DCRED_W-1:0] dcred_nxt;
  logic [HCRED_W-1:0] hcred_nxt;

  assign first_beat = LINK.packet_start_flag & LINK.transmit_valid_flag;

  // id stays frozen between first beats, so later beats cannot disturb it
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pf_r <= PF_RST;
      vf_act_r <= 1'b0;
    end else if (first_beat) begin
      pf_r <= LINK.phys_func_id_in;
      vf_act_r <= LINK.virt_func_flag_in;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      vf_r <= VF_RST;
    end else if (first_beat) begin
      if (LINK.virt_func_flag_in) begin
        vf_r <= LINK.virt_func_offset_in;
      end else begin
        vf_r <= VF_RST;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= first_beat;
    end
  end

  assign TLP_PF_ID = pf_r;
  assign TLP_VF_ACTIVE = vf_act_r;
  assign TLP_VF_OFFSET = vf_r;
  assign TLP_ID_STROBE = strobe_r;

  // reserved select code 11 reports zero limits
  always_comb begin
    dcred_nxt = DCRED_RST;
    hcred_nxt = HCRED_RST;
    unique case (sel_r)
      SEL_POSTED: begin
        dcred_nxt = POSTED_DATA_LIMIT;
        hcred_nxt = POSTED_HDR_LIMIT;
      end
      SEL_NONPOSTED: begin
        dcred_nxt = NONPOSTED_DATA_LIMIT;
        hcred_nxt = NONPOSTED_HDR_LIMIT;
      end
      SEL_CPL: begin
        dcred_nxt = CPL_DATA_LIMIT;
        hcred_nxt = CPL_HDR_LIMIT;
      end
      default: begin
        dcred_nxt = DCRED_RST;
        hcred_nxt = HCRED_RST;
      end
    endcase
  end

  // two register stages: select, then the muxed limits
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sel_r <= SEL_RST;
      dcred_r <= DCRED_RST;
      hcred_r <= HCRED_RST;
    end else begin
      sel_r <= LINK.credit_type_select;
      dcred_r <= dcred_nxt;
      hcred_r <= hcred_nxt;
    end
  end

  assign LINK.data_credit_limit_out = dcred_r;
  assign LINK.header_credit_limit_out = hcred_r;
endmodule : tfcsb_bridge

// ==== hw/tfcsb_pkg.sv ====
// constants shared by both ends of the function id and credit sideband
package tfcsb_pkg;
  localparam int PF_W = 2;
  localparam int VF_W = 11;
  localparam int VF_MAX = 2048;
  localparam int DCRED_W = 12;
  localparam int HCRED_W = 8;
  localparam int SEL_W = 2;
  localparam int DCRED_BYTES = 16;
  localparam int HCRED_BYTES = 20;
  localparam int SEL_LATENCY = 2;
  localparam logic [SEL_W-1:0] SEL_POSTED = 2'h0;
  localparam logic [SEL_W-1:0] SEL_NONPOSTED = 2'h1;
  localparam logic [SEL_W-1:0] SEL_CPL = 2'h2;
  localparam logic [PF_W-1:0] PF_RST = 2'h0;
  localparam logic [VF_W-1:0] VF_RST = 11'h000;
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
  localparam logic [DCRED_W-1:0] DCRED_RST = 12'h000;
  localparam logic [HCRED_W-1:0] HCRED_RST = 8'h00;
endpackage : tfcsb_pkg

// ==== hw/tfcsb_if.sv ====
// interface joining the application end and the bridge end
`timescale 1ns/1ps
interface tfcsb_if;
  import tfcsb_pkg::*;
  logic packet_start_flag;
  logic transmit_valid_flag;
  logic [PF_W-1:0] phys_func_id_in;
  logic virt_func_flag_in;
  logic [VF_W-1:0] virt_func_offset_in;
  logic [SEL_W-1:0] credit_type_select;
  logic [DCRED_W-1:0] data_credit_limit_out;
  logic [HCRED_W-1:0] header_credit_limit_out;
  modport bridge (
    input packet_start_flag,
    input transmit_valid_flag,
    input phys_func_id_in,
    input virt_func_flag_in,
    input virt_func_offset_in,
    input credit_type_select,
    output data_credit_limit_out,
    output header_credit_limit_out
  );
  modport app (
    output packet_start_flag,
    output transmit_valid_flag,
    output phys_func_id_in,
    output virt_func_flag_in,
    output virt_func_offset_in,
    output credit_type_select,
    input data_credit_limit_out,
    input header_credit_limit_out
  );
endinterface : tfcsb_if

// ==== hw/tfcsb_app.sv ====
// application end: drives function id with each packet start and picks the credit type
`timescale 1ns/1ps
module tfcsb_app
  import tfcsb_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  tfcsb_if.app LINK,
  input wire logic SOP,
  input wire logic VALID,
  input wire logic [PF_W-1:0] PF_ID,
  input wire logic VF_ACTIVE,
  input wire logic [VF_W-1:0] VF_OFFSET,
  input wire logic [VF_W:0] VF_COUNT,
  input wire logic [SEL_W-1:0] CRED_SEL,
  output logic [DCRED_W-1:0] DATA_LIMIT,
  output logic [HCRED_W-1:0] HDR_LIMIT,
  output logic VF_RANGE_ERR
);
  logic sop_r;
  logic valid_r;
  logic [PF_W-1:0] pf_r;
  logic vf_act_r;
  logic [VF_W-1:0] vf_r;
  logic [SEL_W-1:0] sel_r;
  logic err_r;
  logic [DCRED_W-1:0] dlim_r;
  logic [HCRED_W-1:0] hlim_r;
  logic vf_ok;

  // offset must sit below the parent's VF count, never past 2048
  assign vf_ok = ({1'b0, VF_OFFSET} < VF_COUNT) && (VF_COUNT <= (VF_W+1)'(VF_MAX));

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sop_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= VALID;
      sop_r <= SOP & VALID;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pf_r <= PF_RST;
      vf_act_r <= 1'b0;
      vf_r <= VF_RST;
    end else begin
      pf_r <= PF_ID;
      vf_act_r <= VF_ACTIVE;
      vf_r <= VF_ACTIVE ? VF_OFFSET : VF_RST;
    end
  end

  // bad offsets are flagged, not blocked, so the bridge sees what software asked for
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      err_r <= 1'b0;
    end else begin
      err_r <= SOP & VALID & VF_ACTIVE & ~vf_ok;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sel_r <= SEL_RST;
      dlim_r <= DCRED_RST;
      hlim_r <= HCRED_RST;
    end else begin
      sel_r <= CRED_SEL;
      dlim_r <= LINK.data_credit_limit_out;
      hlim_r <= LINK.header_credit_limit_out;
    end
  end

  assign LINK.packet_start_flag = sop_r;
  assign LINK.transmit_valid_flag = valid_r;
  assign LINK.phys_func_id_in = pf_r;
  assign LINK.virt_func_flag_in = vf_act_r;
  assign LINK.virt_func_offset_in = vf_r;
  assign LINK.credit_type_select = sel_r;
  assign DATA_LIMIT = dlim_r;
  assign HDR_LIMIT = hlim_r;
  assign VF_RANGE_ERR = err_r;
endmodule : tfcsb_app

// ==== tb/tfcsb_properties.sv ====
// concurrent checks on the sideband link and the bridge capture outputs
`timescale 1ns/1ps
module tfcsb_properties
  import tfcsb_pkg::*;
(
  input logic CLOCK,
  input logic RST_N,
  input logic packet_start_flag,
  input logic transmit_valid_flag,
  input logic [PF_W-1:0] phys_func_id_in,
  input logic virt_func_flag_in,
  input logic [VF_W-1:0] virt_func_offset_in,
  input logic [SEL_W-1:0] credit_type_select,
  input logic [DCRED_W-1:0] data_credit_limit_out,
  input logic [HCRED_W-1:0] header_credit_limit_out,
  input logic [PF_W-1:0] TLP_PF_ID,
  input logic TLP_VF_ACTIVE,
  input logic [VF_W-1:0] TLP_VF_OFFSET,
  input logic TLP_ID_STROBE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence first_beat_s;
    packet_start_flag && transmit_valid_flag;
  endsequence
  // needs distinct limit values per type, else a step shows no change
  sequence sel_step_s;
    $changed(credit_type_select) ##1 $stable(credit_type_select);
  endsequence
  start_valid_a: assert property (packet_start_flag |-> transmit_valid_flag)
    else $error("start flag without valid");
  pf_offset_a: assert property (!virt_func_flag_in |-> virt_func_offset_in == '0)
    else $error("offset not zero for pf packet");
  pf_capture_a: assert property (first_beat_s |=> TLP_ID_STROBE
    && TLP_PF_ID == $past(phys_func_id_in)) else $error("pf id not captured");
  vf_capture_a: assert property (first_beat_s |=> TLP_VF_ACTIVE == $past(virt_func_flag_in)
    && TLP_VF_OFFSET == ($past(virt_func_flag_in) ? $past(virt_func_offset_in) : '0))
    else $error("vf id not captured");
  id_hold_a: assert property (!(packet_start_flag && transmit_valid_flag) |=> !TLP_ID_STROBE
    && $stable(TLP_PF_ID) && $stable(TLP_VF_ACTIVE) && $stable(TLP_VF_OFFSET))
    else $error("id moved outside first beat");
  cred_early_a: assert property ($stable(credit_type_select)[*3] |=>
    $stable(data_credit_limit_out) && $stable(header_credit_limit_out))
    else $error("credit moved without select change");
  cred_step_a: assert property (sel_step_s |=> $changed(data_credit_limit_out)
    && $changed(header_credit_limit_out)) else $error("credit late after select");
  cred_pair_a: assert property ($changed(data_credit_limit_out) |->
    $changed(header_credit_limit_out)) else $error("header and data apart");
endmodule : tfcsb_properties

// ==== tb/tb.sv ====
// self-checking bench joining the application end and the bridge end
`timescale 1ns/1ps
module tb;
  import tfcsb_pkg::*;
  typedef struct packed {
    logic [PF_W-1:0] pf;
    logic vfa;
    logic [VF_W-1:0] off;
    logic [VF_W:0] cnt;
    logic err;
  } tfcsb_row_t;
  localparam tfcsb_row_t ROWS [5] = '{'{2'h1, 1'b0, 11'h005, 12'h010, 1'b0},
    '{2'h2, 1'b1, 11'h005, 12'h010, 1'b0}, '{2'h3, 1'b1, 11'h7FF, 12'h800, 1'b0},
    '{2'h0, 1'b1, 11'h010, 12'h010, 1'b1}, '{2'h1, 1'b1, 11'h000, 12'h801, 1'b1}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sop = 1'b0;
  logic valid = 1'b0;
  logic [PF_W-1:0] pf = '0;
  logic vfa = 1'b0;
  logic [VF_W-1:0] off = '0;
  logic [VF_W:0] cnt = '0;
  logic [SEL_W-1:0] sel = '0;
  // one limit per credit type, all distinct so a select step always shows
  logic [DCRED_W-1:0] ld [3] = '{12'h111, 12'h222, 12'h333};
  logic [HCRED_W-1:0] lh [3] = '{8'h11, 8'h22, 8'h33};
  logic [DCRED_W-1:0] dlim;
  logic [HCRED_W-1:0] hlim;
  logic err, t_vfa, t_stb;
  logic [PF_W-1:0] t_pf;
  logic [VF_W-1:0] t_off;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;
  always #5 clk = ~clk;
  tfcsb_if lk();
  tfcsb_app u_tfcsb_app (.CLOCK(clk), .RST_N(rst_n), .LINK(lk.app), .SOP(sop), .VALID(valid),
    .PF_ID(pf), .VF_ACTIVE(vfa), .VF_OFFSET(off), .VF_COUNT(cnt), .CRED_SEL(sel),
    .DATA_LIMIT(dlim), .HDR_LIMIT(hlim), .VF_RANGE_ERR(err));
  tfcsb_bridge u_tfcsb_bridge (.CLOCK(clk), .RST_N(rst_n), .LINK(lk.bridge),
    .POSTED_DATA_LIMIT(ld[0]), .POSTED_HDR_LIMIT(lh[0]), .NONPOSTED_DATA_LIMIT(ld[1]),
    .NONPOSTED_HDR_LIMIT(lh[1]), .CPL_DATA_LIMIT(ld[2]), .CPL_HDR_LIMIT(lh[2]),
    .TLP_PF_ID(t_pf), .TLP_VF_ACTIVE(t_vfa), .TLP_VF_OFFSET(t_off), .TLP_ID_STROBE(t_stb));
  tfcsb_properties u_chk (.CLOCK(clk), .RST_N(rst_n),
    .packet_start_flag(lk.packet_start_flag), .transmit_valid_flag(lk.transmit_valid_flag),
    .phys_func_id_in(lk.phys_func_id_in), .virt_func_flag_in(lk.virt_func_flag_in),
    .virt_func_offset_in(lk.virt_func_offset_in), .credit_type_select(lk.credit_type_select),
    .data_credit_limit_out(lk.data_credit_limit_out),
    .header_credit_limit_out(lk.header_credit_limit_out),
    .TLP_PF_ID(t_pf), .TLP_VF_ACTIVE(t_vfa), .TLP_VF_OFFSET(t_off), .TLP_ID_STROBE(t_stb));
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    chk("data limit", 12'h000, dlim);
    chk("strobe", 12'h000, 12'(t_stb));
    rst_n = 1'b1;
    foreach (ROWS[i]) begin
      {pf, vfa, off, cnt} = {ROWS[i].pf, ROWS[i].vfa, ROWS[i].off, ROWS[i].cnt};
      sop = 1'b1;
      valid = 1'b1;
      @(negedge clk);
      // the earlier id must survive the later beat that carried flipped inputs
      if (i > 0) begin
        chk("pf hold", 12'(ROWS[i-1].pf), 12'(t_pf));
        chk("vf flag hold", 12'(ROWS[i-1].vfa), 12'(t_vfa));
      end
      chk("strobe", 12'h000, 12'(t_stb));
      sop = 1'b0;
      pf = ~pf;
      vfa = ~vfa;
      off = ~off;
      chk("range err", 12'(ROWS[i].err), 12'(err));
      @(negedge clk);
      chk("pf id", 12'(ROWS[i].pf), 12'(t_pf));
      chk("vf flag", 12'(ROWS[i].vfa), 12'(t_vfa));
      chk("vf offset", ROWS[i].vfa ? 12'(ROWS[i].off) : 12'h000, 12'(t_off));
      chk("strobe", 12'h001, 12'(t_stb));
    end
    // start without valid must not count as a first beat
    valid = 1'b0;
    sop = 1'b1;
    pf = 2'h2;
    repeat (2) @(negedge clk);
    chk("strobe", 12'h000, 12'(t_stb));
    chk("pf hold", 12'(ROWS[4].pf), 12'(t_pf));
    sop = 1'b0;
    for (int s = 0; s < 5; s++) begin
      k = s % 4;
      sel = 2'(k);
      repeat (4) @(negedge clk);
      chk("data limit", k == 3 ? 12'h000 : ld[k], dlim);
      chk("hdr limit", k == 3 ? 12'h000 : 12'(lh[k]), 12'(hlim));
    end
    rst_n = 1'b0;
    @(negedge clk);
    chk("data limit", 12'h000, dlim);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("data limit", ld[0], dlim);
    stop_test();
  end
endmodule : tb
